// *** hdl/tmr_pkg.sv ***
/*
  constants, register map and carrier types of the cascaded timer and
  watchdog block. assumes a 32-bit ahb-lite register bus.
*/
package tmr_pkg;
  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [7:0] OFS_CONFIG = 8'h00;
  localparam logic [7:0] OFS_MODE = 8'h04;
  localparam logic [7:0] OFS_CTRL = 8'h08;
  localparam logic [7:0] OFS_CNT0 = 8'h0c;
  localparam logic [7:0] OFS_CNT1 = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_CLEAR = 8'h18;
  localparam logic [7:0] OFS_ENABLE = 8'h1c;
  localparam logic [7:0] CONFIG_RST = 8'h00;
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [2:0] CTRL_RST = 3'h0;
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [2:0] STAT_RST = 3'h0;
  localparam int CTRL_RUN0 = 0;
  localparam int CTRL_RUN1 = 1;
  localparam int CTRL_PD = 2;
  localparam int STAT_TF0 = 0;
  localparam int STAT_TF1 = 1;
  localparam int STAT_WDR = 2;
  // ----------------------------------------
  // machine cycle timing
  // ----------------------------------------
  localparam int OSC_PER_MC = 12;
  localparam logic [3:0] PH_STATE3_PHASE1 = 4'h4;
  localparam logic [3:0] PH_STATE5_PHASE1 = 4'h8;
  localparam logic [3:0] PH_STATE5_PHASE2 = 4'h9;
  localparam logic [3:0] PH_LAST = 4'hb;
  localparam int WD_RST_MCS = 5;
  localparam int WD_RST_CLKS = WD_RST_MCS * OSC_PER_MC;
  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef struct packed {
    logic watchdog_enable;
    logic cascade_enable;
    logic serial_error_flag;
    logic input_impedance_select;
    logic port3_float;
    logic port2_float;
    logic port1_float;
    logic float_all_in_powerdown;
  } io_cfg_type;
  typedef struct packed {
    logic gate1;
    logic ct1;
    logic [1:0] mode1;
    logic gate0;
    logic ct0;
    logic [1:0] mode0;
  } tmode_type;
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
  } ahb_req_type;
  typedef enum logic [1:0] {
    WD_IDLE = 2'b00,
    WD_WAIT = 2'b01,
    WD_HOLD = 2'b10
  } wd_state_type;
endpackage : tmr_pkg

// *** hdl/cascade_timer.sv ***
/*
  cascaded timer/counter pair with watchdog reset and ahb-lite registers.
  assumes SYS_CLK is the oscillator; twelve clocks form a machine cycle.
*/
// Our own choices: the AHB-Lite interface to the registers and the placing of the registers.
// Function
// - cascade enable joins both timers; counter select picks timer or count
// - watchdog enable turns the timer 1 overflow into a watchdog source
// - timer 0 is the low half, timer 1 the high half
// - cascade enable set runs the 32-bit count, cleared stops it
// - without cascade each timer follows its mode and run bit, except timer 1 ignores its run bit while timer 0 is in mode 3
// - 32-bit timer increments once per machine cycle at state3_phase1
// - cascade carry sets no timer 0 flag; 32-bit wrap sets flag
// - count input sampled once per machine cycle at state5_phase2
// - count increments after a high sample then a later low sample
// - any overflow reaching the timer 1 flag serves as watchdog
// - watchdog counts machine cycles or count input per counter select, except the timer 0 high byte in mode 3 counts machine cycles only
// - watchdog reset starts next machine cycle, lasts five cycles
// - watchdog reset clears configuration, mode and timer registers
// - power-down stops machine cycle counting, input counting goes on
// - power-down overflows still raise flags or watchdog reset
`timescale 1ns/100ps
`default_nettype none
module cascade_timer (
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic EXT_COUNT_IN0,
  input wire logic EXT_COUNT_IN1,
  output logic CPU_RST,
  output logic IRQ
);
  localparam int HOLD_W = $clog2(tmr_pkg::WD_RST_CLKS);
  localparam logic [HOLD_W-1:0] HOLD_END = HOLD_W'(tmr_pkg::WD_RST_CLKS - 1);

  tmr_pkg::io_cfg_type cfg_r, cfg_nxt;
  tmr_pkg::tmode_type mode_r, mode_nxt;
  tmr_pkg::ahb_req_type areq_r, areq_nxt;
  tmr_pkg::wd_state_type wd_state_r, wd_nxt;
  logic [2:0] ctrl_r, ctrl_nxt, stat_r, stat_nxt, en_r, en_nxt;
  logic [15:0] cnt0_r, cnt0_nxt, cnt1_r, cnt1_nxt, c0_nxt, c1_nxt;
  logic [1:0] pend_r, pend_nxt;
  logic [3:0] ph_r, ph_nxt;
  logic [HOLD_W-1:0] hold_r, hold_nxt;
  logic [31:0] hrdata_r, rdata_mux;
  logic rd_wait_r, rst_r;
  logic [1:0] sy1_r, sy2_r, smp_r, edge_w;
  logic ov0, ov1;
  logic [16:0] st0, st1;
  logic [32:0] sum32;

  // ----------------------------------------
  // machine cycle phases
  // ----------------------------------------
  wire ph_last = ph_r == tmr_pkg::PH_LAST;
  wire state3_phase1 = ph_r == tmr_pkg::PH_STATE3_PHASE1;
  wire state5_phase1 = ph_r == tmr_pkg::PH_STATE5_PHASE1;
  wire state5_phase2 = ph_r == tmr_pkg::PH_STATE5_PHASE2;
  wire pd = ctrl_r[tmr_pkg::CTRL_PD];
  wire mc_tick = state3_phase1 & ~pd;
  assign ph_nxt = ph_last ? 4'h0 : ph_r + 4'h1;

  // ----------------------------------------
  // count input sampling
  // ----------------------------------------
  wire [1:0] ext_in = {EXT_COUNT_IN1, EXT_COUNT_IN0};
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_in
      always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
          sy1_r[gi] <= 1'b0;
          sy2_r[gi] <= 1'b0;
          smp_r[gi] <= 1'b0;
        end else begin
          sy1_r[gi] <= ext_in[gi];
          sy2_r[gi] <= sy1_r[gi];
          if (state5_phase2) begin
            smp_r[gi] <= sy2_r[gi];
          end
        end
      end
      assign edge_w[gi] = state5_phase2 & smp_r[gi] & ~sy2_r[gi];
    end
  endgenerate

  // ----------------------------------------
  // increment sources
  // ----------------------------------------
  wire casc = cfg_r.cascade_enable;
  wire run0 = ctrl_r[tmr_pkg::CTRL_RUN0];
  wire run1 = ctrl_r[tmr_pkg::CTRL_RUN1];
  wire split0 = mode_r.mode0 == 2'd3;
  wire src0 = mode_r.ct0 ? edge_w[0] : mc_tick;
  wire src1 = mode_r.ct1 ? edge_w[1] : mc_tick;
  wire casc_inc = casc & src0;
  wire inc0 = ~casc & run0 & src0;
  wire th0_inc = ~casc & split0 & run1 & mc_tick;
  wire run1_eff = split0 ? 1'b1 : run1;
  wire inc1 = ~casc & run1_eff & src1 & (mode_r.mode1 != 2'd3);

  function automatic logic [16:0] step16(input logic [15:0] v,
                                         input logic [1:0] m);
    logic [12:0] t13;
    logic [7:0] tl;
    t13 = {v[15:8], v[4:0]} + 13'd1;
    tl = v[7:0] + 8'h01;
    case (m)
      2'd0: step16 = {&{v[15:8], v[4:0]}, t13[12:5], v[7:5], t13[4:0]};
      2'd1: step16 = {&v, v + 16'h0001};
      2'd2: step16 = {&v[7:0], v[15:8], (&v[7:0]) ? v[15:8] : tl};
      default: step16 = {1'b0, v};
    endcase
  endfunction : step16

  // ----------------------------------------
  // counting
  // ----------------------------------------
  assign st0 = step16(cnt0_r, mode_r.mode0);
  assign st1 = step16(cnt1_r, mode_r.mode1);
  assign sum32 = {1'b0, cnt1_r, cnt0_r} + 33'd1;

  always_comb begin
    c0_nxt = cnt0_r;
    c1_nxt = cnt1_r;
    ov0 = 1'b0;
    ov1 = 1'b0;
    if (casc_inc) begin
      {ov1, c1_nxt, c0_nxt} = sum32;
    end
    if (inc0 && split0) begin
      c0_nxt[7:0] = cnt0_r[7:0] + 8'h01;
      ov0 = &cnt0_r[7:0];
    end else if (inc0) begin
      {ov0, c0_nxt} = st0;
    end
    if (th0_inc) begin
      c0_nxt[15:8] = cnt0_r[15:8] + 8'h01;
      ov1 = &cnt0_r[15:8];
    end
    if (inc1) begin
      c1_nxt = st1[15:0];
      ov1 = ov1 | st1[16];
    end
  end

  // ----------------------------------------
  // overflow flags and watchdog
  // ----------------------------------------
  wire soft_clr = wd_state_r == tmr_pkg::WD_HOLD;
  wire [1:0] tf_set = {2{state5_phase1}} & pend_r;
  wire wd_fire = tf_set[1] & cfg_r.watchdog_enable;
  wire wd_start = (wd_state_r == tmr_pkg::WD_WAIT) & ph_last;
  assign pend_nxt = soft_clr ? 2'b00 :
                    ((pend_r & ~{2{state5_phase1}}) | {ov1, ov0});
  assign hold_nxt = soft_clr ? hold_r + 1'b1 : '0;

  always_comb begin
    case (wd_state_r)
      tmr_pkg::WD_IDLE: wd_nxt = wd_fire ? tmr_pkg::WD_WAIT
                                         : tmr_pkg::WD_IDLE;
      tmr_pkg::WD_WAIT: wd_nxt = ph_last ? tmr_pkg::WD_HOLD
                                         : tmr_pkg::WD_WAIT;
      tmr_pkg::WD_HOLD: wd_nxt = (hold_r == HOLD_END) ? tmr_pkg::WD_IDLE
                                                      : tmr_pkg::WD_HOLD;
      default: wd_nxt = tmr_pkg::WD_IDLE;
    endcase
  end

  // ----------------------------------------
  // ahb-lite slave
  // ----------------------------------------
  wire take = HSEL & HTRANS[1] & HREADY;
  assign areq_nxt = take ? {1'b1, HWRITE, HADDR[7:0]} : '0;
  wire wr_en = areq_r.valid & areq_r.write;
  wire rd_en = areq_r.valid & ~areq_r.write;
  wire wsel_cfg = wr_en & (areq_r.addr == tmr_pkg::OFS_CONFIG);
  wire wsel_mode = wr_en & (areq_r.addr == tmr_pkg::OFS_MODE);
  wire wsel_ctrl = wr_en & (areq_r.addr == tmr_pkg::OFS_CTRL);
  wire wsel_cnt0 = wr_en & (areq_r.addr == tmr_pkg::OFS_CNT0);
  wire wsel_cnt1 = wr_en & (areq_r.addr == tmr_pkg::OFS_CNT1);
  wire wsel_clr = wr_en & (areq_r.addr == tmr_pkg::OFS_CLEAR);
  wire wsel_en = wr_en & (areq_r.addr == tmr_pkg::OFS_ENABLE);
  wire [2:0] clr_bits = wsel_clr ? HWDATA[2:0] : 3'h0;
  wire [2:0] set_bits = {wd_start, tf_set};

  assign cfg_nxt = soft_clr ? tmr_pkg::io_cfg_type'(tmr_pkg::CONFIG_RST) :
                   wsel_cfg ? tmr_pkg::io_cfg_type'(HWDATA[7:0]) :
                   cfg_r;
  assign mode_nxt = soft_clr ? tmr_pkg::tmode_type'(tmr_pkg::MODE_RST) :
                    wsel_mode ? tmr_pkg::tmode_type'(HWDATA[7:0]) :
                    mode_r;
  assign ctrl_nxt = soft_clr ? tmr_pkg::CTRL_RST :
                    wsel_ctrl ? HWDATA[2:0] : ctrl_r;
  assign cnt0_nxt = soft_clr ? tmr_pkg::CNT_RST :
                    wsel_cnt0 ? HWDATA[15:0] : c0_nxt;
  assign cnt1_nxt = soft_clr ? tmr_pkg::CNT_RST :
                    wsel_cnt1 ? HWDATA[15:0] : c1_nxt;
  assign stat_nxt = (stat_r & ~clr_bits & ~{1'b0, {2{soft_clr}}}) |
                    set_bits;
  assign en_nxt = wsel_en ? HWDATA[2:0] : en_r;

  wire [7:0] ra = areq_r.addr;
  assign rdata_mux =
    (ra == tmr_pkg::OFS_CONFIG) ? {24'h0, cfg_r} :
    (ra == tmr_pkg::OFS_MODE) ? {24'h0, mode_r} :
    (ra == tmr_pkg::OFS_CTRL) ? {29'h0, ctrl_r} :
    (ra == tmr_pkg::OFS_CNT0) ? {16'h0, cnt0_r} :
    (ra == tmr_pkg::OFS_CNT1) ? {16'h0, cnt1_r} :
    (ra == tmr_pkg::OFS_STATUS) ? {29'h0, stat_r} :
    (ra == tmr_pkg::OFS_ENABLE) ? {29'h0, en_r} : 32'h0;

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      cfg_r <= tmr_pkg::io_cfg_type'(tmr_pkg::CONFIG_RST);
      mode_r <= tmr_pkg::tmode_type'(tmr_pkg::MODE_RST);
      ctrl_r <= tmr_pkg::CTRL_RST;
      cnt0_r <= tmr_pkg::CNT_RST;
      cnt1_r <= tmr_pkg::CNT_RST;
      stat_r <= tmr_pkg::STAT_RST;
      en_r <= tmr_pkg::STAT_RST;
      pend_r <= 2'b00;
      ph_r <= 4'h0;
    end else begin
      cfg_r <= cfg_nxt;
      mode_r <= mode_nxt;
      ctrl_r <= ctrl_nxt;
      cnt0_r <= cnt0_nxt;
      cnt1_r <= cnt1_nxt;
      stat_r <= stat_nxt;
      en_r <= en_nxt;
      pend_r <= pend_nxt;
      ph_r <= ph_nxt;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      wd_state_r <= tmr_pkg::WD_IDLE;
      hold_r <= '0;
      rst_r <= 1'b0;
      areq_r <= '0;
      rd_wait_r <= 1'b0;
      hrdata_r <= 32'h0;
    end else begin
      wd_state_r <= wd_nxt;
      hold_r <= hold_nxt;
      rst_r <= wd_nxt == tmr_pkg::WD_HOLD;
      areq_r <= areq_nxt;
      rd_wait_r <= take & ~HWRITE;
      if (rd_en) begin
        hrdata_r <= rdata_mux;
      end
    end
  end

  assign HRDATA = hrdata_r;
  assign HREADYOUT = ~rd_wait_r;
  assign HRESP = 1'b0;
  assign CPU_RST = rst_r;
  assign IRQ = |(stat_r & en_r);

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence rst_window;
    ##59 CPU_RST ##1 !CPU_RST;
  endsequence

  a_rst_length: assert property (
    @(posedge SYS_CLK) disable iff (!RST_N)
    $rose(CPU_RST) |-> rst_window)
    else $error("watchdog reset length wrong");

  a_rst_start: assert property (
    @(posedge SYS_CLK) disable iff (!RST_N)
    (wd_fire && wd_state_r == tmr_pkg::WD_IDLE) |-> ##4 $rose(CPU_RST))
    else $error("watchdog reset not started next machine cycle");

  a_cfg_cleared: assert property (
    @(posedge SYS_CLK) disable iff (!RST_N)
    CPU_RST |=> (cfg_r == tmr_pkg::CONFIG_RST && cnt1_r == 16'h0000))
    else $error("registers not cleared by watchdog reset");

  a_casc_carry: assert property (
    @(posedge SYS_CLK) disable iff (!RST_N)
    (casc_inc && cnt0_r == 16'hffff && !soft_clr && !wr_en)
      |=> cnt1_r == $past(cnt1_r) + 16'h0001 && cnt0_r == 16'h0000)
    else $error("low half carry did not reach high half");

  a_tf0_quiet: assert property (
    @(posedge SYS_CLK) disable iff (!RST_N)
    (casc && !split0) |=> !$rose(pend_r[0]))
    else $error("timer 0 flag armed in cascade");

  a_flag_phase: assert property (
    @(posedge SYS_CLK) disable iff (!RST_N)
    $rose(stat_r[tmr_pkg::STAT_TF1]) |-> $past(ph_r) == tmr_pkg::PH_STATE5_PHASE1)
    else $error("overflow flag set outside state5_phase1");

  a_tick_phase: assert property (
    @(posedge SYS_CLK) disable iff (!RST_N)
    (casc && !mode_r.ct0 && !wr_en && !soft_clr && cnt0_nxt != cnt0_r)
      |-> ph_r == tmr_pkg::PH_STATE3_PHASE1 && !pd)
    else $error("32-bit timer moved outside state3_phase1");

  a_cnt_edge: assert property (
    @(posedge SYS_CLK) disable iff (!RST_N)
    (casc && mode_r.ct0 && !wr_en && !soft_clr && cnt0_nxt != cnt0_r)
      |-> state5_phase2 && smp_r[0] && !sy2_r[0])
    else $error("counter moved without a falling edge");
endmodule : cascade_timer
`default_nettype wire

// *** verification/ext_side.sv ***
/*
  far side model: external count inputs and cpu reset length monitor.
  assumes one clock shared with the timer block.
*/
`timescale 1ns/100ps
`default_nettype none
module ext_side (
  input wire logic clk,
  input wire logic cpu_rst,
  output logic ext0,
  output logic ext1,
  output int rst_len
);
  logic prev_r;
  initial begin
    ext0 = 1'b0;
    ext1 = 1'b0;
    rst_len = 0;
    prev_r = 1'b0;
  end
  // ----------------------------------------
  // reset length in clocks
  // ----------------------------------------
  always @(posedge clk) begin
    prev_r <= cpu_rst;
    if (cpu_rst && !prev_r)
      rst_len <= 1;
    else if (cpu_rst)
      rst_len <= rst_len + 1;
  end
  // ----------------------------------------
  // count pulses, three machine cycles each
  // ----------------------------------------
  task pulse(input int ch, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      if (ch == 0) ext0 <= 1'b1; else ext1 <= 1'b1;
      repeat (18) @(posedge clk);
      if (ch == 0) ext0 <= 1'b0; else ext1 <= 1'b0;
      repeat (17) @(posedge clk);
    end
  endtask : pulse
endmodule : ext_side
`default_nettype wire

// *** verification/cascade_timer_tb.sv ***
/*
  self-checking bench of the cascaded timer and watchdog.
  assumes tmr_pkg and the ext_side model are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
module cascade_timer_tb;
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wd;
    logic [31:0] exp;
  } row_type;
  logic clk, rst_n, hwrite, hready, hresp, cpu_rst, irq, ext0, ext1;
  logic [31:0] haddr, hwdata, hrdata, v;
  logic [1:0] htrans;
  int mismatches, total_checks, rst_len, n;
  row_type rows [9];
  cascade_timer uut (.SYS_CLK(clk), .RST_N(rst_n), .HSEL(1'b1),
    .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2),
    .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata),
    .HREADYOUT(hready), .HRESP(hresp), .EXT_COUNT_IN0(ext0),
    .EXT_COUNT_IN1(ext1), .CPU_RST(cpu_rst), .IRQ(irq));
  ext_side ext (.clk(clk), .cpu_rst(cpu_rst), .ext0(ext0), .ext1(ext1),
    .rst_len(rst_len));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task test_done;
    $display("checks=%0d mismatches=%0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : test_done
  task check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int k;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= wr;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (hready !== 1'b1 && k < 50);
    htrans <= 2'b00;
    hwdata <= wd;
    do begin
      @(posedge clk);
      k++;
    end while (hready !== 1'b1 && k < 50);
    v = hrdata;
    if (k >= 50) begin
      mismatches++;
      test_done();
    end
  endtask : ahb
  task wr(input logic [7:0] a, input logic [31:0] d);
    ahb(1'b1, a, d);
  endtask : wr
  task rdc(input logic [7:0] a, input logic [31:0] exp);
    ahb(1'b0, a, 32'h0);
    check(v, exp);
  endtask : rdc
  task irqc(input logic exp);
    @(posedge clk);
    check({31'h0, irq}, {31'h0, exp});
  endtask : irqc
  task wait_rst(input logic lvl);
    n = 0;
    while (cpu_rst !== lvl && n < 500) begin
      @(posedge clk);
      n++;
    end
    if (n >= 500) begin
      mismatches++;
      test_done();
    end
  endtask : wait_rst
  // ----------------------------------------
  // clock and limit
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    #2000000;
    mismatches++;
    test_done();
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    mismatches = 0;
    total_checks = 0;
    rst_n = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hwdata = 32'h0;
    rows = '{'{tmr_pkg::OFS_CONFIG, 32'h3f, 32'h3f},
      '{tmr_pkg::OFS_MODE, 32'h5a, 32'h5a},
      '{tmr_pkg::OFS_CNT0, 32'h1234, 32'h1234},
      '{tmr_pkg::OFS_CNT1, 32'habcd, 32'habcd},
      '{tmr_pkg::OFS_CTRL, 32'h4, 32'h4},
      '{tmr_pkg::OFS_ENABLE, 32'h7, 32'h7},
      '{tmr_pkg::OFS_CLEAR, 32'h7, 32'h0},
      '{tmr_pkg::OFS_STATUS, 32'h7, 32'h0},
      '{8'h20, 32'hff, 32'h0}};
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 9; i++) begin
      rdc(rows[i].addr, 32'h0);
      wr(rows[i].addr, rows[i].wd);
      rdc(rows[i].addr, rows[i].exp);
    end
    wr(tmr_pkg::OFS_CONFIG, 32'h0);
    wr(tmr_pkg::OFS_MODE, 32'h0);
    wr(tmr_pkg::OFS_CTRL, 32'h0);
    wr(tmr_pkg::OFS_CNT0, 32'h0);
    wr(tmr_pkg::OFS_CNT1, 32'h0);
    // cascade timer rate, then stop
    wr(tmr_pkg::OFS_CONFIG, 32'h40);
    repeat (120) @(posedge clk);
    wr(tmr_pkg::OFS_CONFIG, 32'h0);
    wr(tmr_pkg::OFS_CTRL, 32'h0);
    ahb(1'b0, tmr_pkg::OFS_CNT0, 32'h0);
    check({31'h0, v >= 10 && v <= 11}, 32'h1);
    rdc(tmr_pkg::OFS_CNT1, 32'h0);
    // cascade timer wrap and interrupt
    wr(tmr_pkg::OFS_CNT0, 32'hfff0);
    wr(tmr_pkg::OFS_CNT1, 32'hffff);
    wr(tmr_pkg::OFS_CONFIG, 32'h40);
    n = 0;
    do begin
      ahb(1'b0, tmr_pkg::OFS_STATUS, 32'h0);
      n++;
    end while (v[1] !== 1'b1 && n < 150);
    check(v, 32'h2);
    wr(tmr_pkg::OFS_CONFIG, 32'h0);
    rdc(tmr_pkg::OFS_CNT1, 32'h0);
    irqc(1'b1);
    wr(tmr_pkg::OFS_ENABLE, 32'h1);
    irqc(1'b0);
    wr(tmr_pkg::OFS_ENABLE, 32'h2);
    irqc(1'b1);
    wr(tmr_pkg::OFS_CLEAR, 32'h2);
    irqc(1'b0);
    // cascade counter on falling edges
    wr(tmr_pkg::OFS_CNT0, 32'hfffe);
    wr(tmr_pkg::OFS_CNT1, 32'hffff);
    wr(tmr_pkg::OFS_MODE, 32'h04);
    wr(tmr_pkg::OFS_CONFIG, 32'h40);
    ext.pulse(0, 2);
    repeat (36) @(posedge clk);
    rdc(tmr_pkg::OFS_STATUS, 32'h2);
    rdc(tmr_pkg::OFS_CNT0, 32'h0);
    wr(tmr_pkg::OFS_CONFIG, 32'h0);
    wr(tmr_pkg::OFS_CLEAR, 32'h2);
    // power-down: pin counting goes on, timer ticks stop
    wr(tmr_pkg::OFS_MODE, 32'h05);
    wr(tmr_pkg::OFS_CNT0, 32'h0);
    wr(tmr_pkg::OFS_CTRL, 32'h5);
    ext.pulse(0, 3);
    repeat (36) @(posedge clk);
    rdc(tmr_pkg::OFS_CNT0, 32'h3);
    wr(tmr_pkg::OFS_MODE, 32'h01);
    wr(tmr_pkg::OFS_CNT0, 32'h0);
    repeat (48) @(posedge clk);
    rdc(tmr_pkg::OFS_CNT0, 32'h0);
    wr(tmr_pkg::OFS_CTRL, 32'h1);
    repeat (48) @(posedge clk);
    ahb(1'b0, tmr_pkg::OFS_CNT0, 32'h0);
    check({31'h0, v != 0}, 32'h1);
    wr(tmr_pkg::OFS_CTRL, 32'h0);
    // watchdog on the cascade, one bit at a time
    wr(tmr_pkg::OFS_MODE, 32'h0);
    wr(tmr_pkg::OFS_CNT0, 32'hfff0);
    wr(tmr_pkg::OFS_CNT1, 32'hffff);
    wr(tmr_pkg::OFS_CONFIG, 32'h40);
    wr(tmr_pkg::OFS_CONFIG, 32'hc0);
    wait_rst(1'b1);
    wait_rst(1'b0);
    check(32'(rst_len), 32'd60);
    rdc(tmr_pkg::OFS_CONFIG, 32'h0);
    rdc(tmr_pkg::OFS_STATUS, 32'h4);
    rdc(tmr_pkg::OFS_CNT1, 32'h0);
    // watchdog on the timer 0 high byte in mode 3
    wr(tmr_pkg::OFS_CLEAR, 32'h4);
    wr(tmr_pkg::OFS_MODE, 32'h03);
    wr(tmr_pkg::OFS_CNT0, 32'hff00);
    wr(tmr_pkg::OFS_CONFIG, 32'h80);
    wr(tmr_pkg::OFS_CTRL, 32'h2);
    wait_rst(1'b1);
    wait_rst(1'b0);
    check(32'(rst_len), 32'd60);
    rdc(tmr_pkg::OFS_STATUS, 32'h4);
    rdc(tmr_pkg::OFS_CTRL, 32'h0);
    rdc(tmr_pkg::OFS_MODE, 32'h0);
    // hardware reset in mid-run
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    check({28'h0, hready, hresp, irq, cpu_rst}, 32'h8);
    rst_n <= 1'b1;
    rdc(tmr_pkg::OFS_STATUS, 32'h0);
    rdc(tmr_pkg::OFS_ENABLE, 32'h0);
    test_done();
  end
endmodule : cascade_timer_tb
`default_nettype wire
